/* verilog/csi_consts.svh */
// constants of the cpu system interface: strap codes, factors, i/o ports, cache size
// assumes inclusion by the package and the design modules
`ifndef CSI_CONSTS_SVH
`define CSI_CONSTS_SVH

`define CSI_MSEL_W 3
`define CSI_MSEL_TEST 3'h0
`define CSI_MSEL_X10 3'h1
`define CSI_MSEL_X9 3'h2
`define CSI_MSEL_X5 3'h3
`define CSI_MSEL_X4 3'h4
`define CSI_MSEL_X6 3'h5
`define CSI_MSEL_X7 3'h6
`define CSI_MSEL_X8 3'h7
`define CSI_FACTOR_W 4
`define CSI_FACTOR_MAX 4'hA
`define CSI_FACTOR_TEST 4'h4
`define CSI_IO_ADDR_W 16
`define CSI_IO_FP_CLR0 16'h00F0
`define CSI_IO_FP_CLR1 16'h00F1
`define CSI_CACHE_IDX_W 4
`define CSI_CACHE_LAST 4'hF

`endif

/* verilog/csi_pkg.sv */
// types and the strap decode function of the cpu system interface
// assumes csi_consts.svh on the include path
`default_nettype none
`include "csi_consts.svh"

package csi_pkg;

  typedef enum logic [3:0] {
    CSI_ST_RESET = 4'h1,
    CSI_ST_RUN = 4'h2,
    CSI_ST_IRQ = 4'h4,
    CSI_ST_SMM = 4'h8
  } csi_state_t;

  typedef struct packed {
    logic valid;
    logic [`CSI_IO_ADDR_W-1:0] addr;
  } csi_io_wr_t;

  typedef struct packed {
    logic en;
    logic [`CSI_CACHE_IDX_W-1:0] idx;
    logic val;
  } csi_vwr_t;

  function automatic logic [`CSI_FACTOR_W-1:0] csi_factor(input logic [`CSI_MSEL_W-1:0] code);
    logic [`CSI_FACTOR_W-1:0] f;
    f = `CSI_FACTOR_TEST;
    case (code)
      `CSI_MSEL_X10: f = 4'hA;
      `CSI_MSEL_X9: f = 4'h9;
      `CSI_MSEL_X5: f = 4'h5;
      `CSI_MSEL_X4: f = 4'h4;
      `CSI_MSEL_X6: f = 4'h6;
      `CSI_MSEL_X7: f = 4'h7;
      `CSI_MSEL_X8: f = 4'h8;
      default: f = `CSI_FACTOR_TEST;
    endcase
    if (f > `CSI_FACTOR_MAX) begin
      f = `CSI_FACTOR_MAX;
    end
    return f;
  endfunction

endpackage

`default_nettype wire

/* verilog/csi_mult_sel.sv */
// core multiplier strap capture and decode
// assumes straps stable around reset release; captured while in reset
`timescale 1ns/10ps
`default_nettype none
`include "csi_consts.svh"

module csi_mult_sel (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic capture,
  input wire logic [`CSI_MSEL_W-1:0] core_multiplier_select,
  output logic [`CSI_FACTOR_W-1:0] factor_q,
  output logic test_mode_q
);

  // straps only matter while in reset; a change at run time is ignored
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      factor_q <= `CSI_FACTOR_TEST;
      test_mode_q <= 1'b0;
    end else if (capture) begin
      factor_q <= csi_pkg::csi_factor(core_multiplier_select);
      test_mode_q <= (core_multiplier_select == `CSI_MSEL_TEST);
    end
  end

  factor_ceiling_a: assert property (@(posedge ref_clk) disable iff (srst)
    factor_q <= `CSI_FACTOR_MAX && factor_q != 4'h0)
    else $error("core factor out of range");

  test_code_a: assert property (@(posedge ref_clk) disable iff (srst)
    capture && core_multiplier_select == `CSI_MSEL_TEST |=>
      test_mode_q && factor_q == `CSI_FACTOR_TEST)
    else $error("test strap not decoded as factor four");

  ten_code_a: assert property (@(posedge ref_clk) disable iff (srst)
    capture && core_multiplier_select == `CSI_MSEL_X10 |=> factor_q == 4'hA && !test_mode_q)
    else $error("strap 001 not decoded as ten");

endmodule

`default_nettype wire

/* verilog/csi_valid_mem.sv */
// valid-bit store of the on-chip cache, one bit per line
// assumes one write and one read per cycle; read data registered
`timescale 1ns/10ps
`default_nettype none
`include "csi_consts.svh"

module csi_valid_mem (
  input wire logic ref_clk,
  input wire csi_pkg::csi_vwr_t wr,
  input wire logic [`CSI_CACHE_IDX_W-1:0] rd_idx,
  output logic rd_val_q
);

  logic mem_q [0:(1<<`CSI_CACHE_IDX_W)-1];

  // contents are not reset here; the owner sweeps them clear
  always_ff @(posedge ref_clk) begin
    if (wr.en) begin
      mem_q[wr.idx] <= wr.val;
    end
  end

  always_ff @(posedge ref_clk) begin
    rd_val_q <= mem_q[rd_idx];
  end

endmodule

`default_nettype wire

/* verilog/csi_sys_if.sv */
// cpu system interface: reset handling, clock strap, interrupt entry, fp error line
// assumes all pins synchronous to ref_clk except ext_reset_in, which is synchronised
// Notes on behaviour
// - strap 001..111 select core factors 10,9,5,4,6,7,8.
// - strap 000 gives factor four, test use only.
// - core factor never exceeds ten.
// - reset aborts all work and enters the reset state.
// - after reset everything starts from a known state.
// - reset invalidates every cache line.
// - external reset is synchronised and taken at a defined edge.
// - level request with interrupts enabled starts the service routine.
// - maskable request ignored while the interrupt-enable flag is clear.
// - floating-point error raises the fp error interrupt line.
// - i/o write to F0h or F1h drops the fp error line.
// - low system-management request puts the core in management state.
`timescale 1ns/10ps
`default_nettype none
`include "csi_consts.svh"

module csi_sys_if (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ext_reset_in,
  input wire logic [`CSI_MSEL_W-1:0] core_multiplier_select,
  input wire logic maskable_irq_in,
  input wire logic flags_if_bit,
  input wire logic irq_service_done,
  input wire logic sys_mgmt_irq_n,
  input wire logic fp_error_event,
  input wire csi_pkg::csi_io_wr_t io_wr,
  input wire logic cache_fill,
  input wire logic [`CSI_CACHE_IDX_W-1:0] cache_fill_idx,
  input wire logic [`CSI_CACHE_IDX_W-1:0] cache_lookup_idx,
  output logic cache_line_valid,
  output logic fp_error_irq_out,
  output logic irq_take,
  output logic core_in_reset,
  output logic system_management_state,
  output logic in_irq_service,
  output logic [`CSI_FACTOR_W-1:0] core_factor,
  output logic core_test_mode
);

  logic rst_meta_q;
  logic rst_sync_q;
  logic core_rst;
  csi_pkg::csi_state_t state_q;
  csi_pkg::csi_state_t state_d;
  logic [`CSI_CACHE_IDX_W-1:0] sweep_idx_q;
  logic sweep_done_q;
  logic fp_irq_q;
  logic irq_take_q;
  logic fp_clear_wr;
  logic smi_req;
  logic irq_req;
  csi_pkg::csi_vwr_t vwr;
  logic vmem_rd;

  // two-stage synchroniser; the edge it is seen on is fixed by these flops
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= 1'b1;
    end else begin
      rst_meta_q <= ext_reset_in;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign core_rst = srst | rst_sync_q;

  assign smi_req = ~sys_mgmt_irq_n;
  assign irq_req = maskable_irq_in & flags_if_bit;
  assign fp_clear_wr = io_wr.valid &&
    (io_wr.addr == `CSI_IO_FP_CLR0 || io_wr.addr == `CSI_IO_FP_CLR1);

  // management request outranks the maskable request
  always_comb begin
    state_d = state_q;
    case (state_q)
      csi_pkg::CSI_ST_RESET: begin
        if (sweep_done_q) begin
          state_d = csi_pkg::CSI_ST_RUN;
        end
      end
      csi_pkg::CSI_ST_RUN: begin
        if (smi_req) begin
          state_d = csi_pkg::CSI_ST_SMM;
        end else if (irq_req) begin
          state_d = csi_pkg::CSI_ST_IRQ;
        end
      end
      csi_pkg::CSI_ST_IRQ: begin
        if (smi_req) begin
          state_d = csi_pkg::CSI_ST_SMM;
        end else if (irq_service_done) begin
          state_d = csi_pkg::CSI_ST_RUN;
        end
      end
      csi_pkg::CSI_ST_SMM: begin
        if (!smi_req) begin
          state_d = csi_pkg::CSI_ST_RUN;
        end
      end
      default: state_d = csi_pkg::CSI_ST_RESET;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      state_q <= csi_pkg::CSI_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // one-cycle acknowledge when the service routine is entered
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      irq_take_q <= 1'b0;
    end else begin
      irq_take_q <= (state_q == csi_pkg::CSI_ST_RUN) && !smi_req && irq_req;
    end
  end

  // sweep restarts on every reset, so a short pulse still clears every line
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      sweep_idx_q <= '0;
      sweep_done_q <= 1'b0;
    end else if (state_q == csi_pkg::CSI_ST_RESET && !sweep_done_q) begin
      sweep_idx_q <= sweep_idx_q + 4'h1;
      sweep_done_q <= (sweep_idx_q == `CSI_CACHE_LAST);
    end
  end

  // fills are refused until the sweep has finished
  always_comb begin
    vwr.en = 1'b0;
    vwr.idx = cache_fill_idx;
    vwr.val = 1'b1;
    if (state_q == csi_pkg::CSI_ST_RESET) begin
      vwr.en = !sweep_done_q || core_rst;
      vwr.idx = sweep_idx_q;
      vwr.val = 1'b0;
    end else if (cache_fill) begin
      vwr.en = 1'b1;
    end
  end

  csi_valid_mem u_vmem (
    .ref_clk(ref_clk),
    .wr(vwr),
    .rd_idx(cache_lookup_idx),
    .rd_val_q(vmem_rd)
  );

  csi_mult_sel u_mult (
    .ref_clk(ref_clk),
    .srst(srst),
    .capture(core_rst),
    .core_multiplier_select(core_multiplier_select),
    .factor_q(core_factor),
    .test_mode_q(core_test_mode)
  );

  // set wins over a same-cycle clear so no error is lost
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      fp_irq_q <= 1'b0;
    end else if (fp_error_event) begin
      fp_irq_q <= 1'b1;
    end else if (fp_clear_wr) begin
      fp_irq_q <= 1'b0;
    end
  end

  assign fp_error_irq_out = fp_irq_q;
  assign irq_take = irq_take_q;
  assign core_in_reset = (state_q == csi_pkg::CSI_ST_RESET);
  assign system_management_state = (state_q == csi_pkg::CSI_ST_SMM);
  assign in_irq_service = (state_q == csi_pkg::CSI_ST_IRQ);
  assign cache_line_valid = vmem_rd & ~core_in_reset;

  fp_set_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    fp_error_event |=> fp_error_irq_out)
    else $error("fp error did not raise the line");

  fp_clear_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    fp_clear_wr && !fp_error_event |=> !fp_error_irq_out)
    else $error("write to clear port left the line high");

  fp_hold_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    fp_error_irq_out && !fp_clear_wr |=> fp_error_irq_out)
    else $error("fp error line dropped without a clear");

  fp_reset_a: assert property (@(posedge ref_clk)
    srst |=> !fp_error_irq_out && core_in_reset)
    else $error("reset left fp line or state active");

  irq_masked_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    state_q == csi_pkg::CSI_ST_RUN && !flags_if_bit && !smi_req |=>
      !in_irq_service && !irq_take)
    else $error("masked request was taken");

  irq_entry_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    state_q == csi_pkg::CSI_ST_RUN && irq_req && !smi_req |=> irq_take && in_irq_service)
    else $error("enabled request not serviced");

  smm_entry_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    smi_req && !core_in_reset |=> system_management_state)
    else $error("management request not honoured");

  ext_reset_a: assert property (@(posedge ref_clk) disable iff (srst)
    ext_reset_in |-> ##3 core_in_reset)
    else $error("external reset not seen after two stages");

  sweep_len_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    $fell(core_rst) |-> core_in_reset [*8] ##0 vwr.en && !vwr.val)
    else $error("sweep ended early or wrote a valid bit");

  irq_take_pulse_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    irq_take |=> !irq_take)
    else $error("service acknowledge longer than one cycle");

  irq_exit_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    in_irq_service && irq_service_done && !smi_req |=>
      !in_irq_service && !system_management_state)
    else $error("service routine did not return to run");

  irq_hold_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    in_irq_service && !irq_service_done && !smi_req |=> in_irq_service)
    else $error("service routine left without completion");

  smm_over_irq_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    smi_req && maskable_irq_in && flags_if_bit && !core_in_reset |=>
      system_management_state && !irq_take)
    else $error("maskable request beat the management request");

  smm_exit_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    system_management_state && !smi_req |=>
      !system_management_state && !in_irq_service && !core_in_reset)
    else $error("management state not left when request dropped");

  reset_known_a: assert property (@(posedge ref_clk)
    core_rst |=> core_in_reset && !irq_take && !in_irq_service &&
      !system_management_state && !fp_error_irq_out)
    else $error("reset did not reach the known state");

  state_onehot_a: assert property (@(posedge ref_clk) disable iff (srst)
    $onehot(state_q))
    else $error("state register not one-hot");

  run_after_sweep_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    core_in_reset && sweep_done_q |=> !core_in_reset)
    else $error("core did not start after the sweep");

  sweep_stay_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    core_in_reset && !sweep_done_q |=> core_in_reset)
    else $error("core left reset before the sweep ended");

  sweep_clear_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    core_in_reset && !sweep_done_q |->
      vwr.en && !vwr.val && vwr.idx == sweep_idx_q)
    else $error("sweep cycle wrote no invalid line");

  fill_refused_a: assert property (@(posedge ref_clk) disable iff (srst)
    core_in_reset |-> !(vwr.en && vwr.val))
    else $error("line marked valid during reset");

  sweep_all_lines_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    $rose(sweep_done_q) |->
      $past(sweep_idx_q) == `CSI_CACHE_LAST)
    else $error("sweep finished before the last line");

  fp_quiet_a: assert property (@(posedge ref_clk) disable iff (core_rst)
    !fp_error_irq_out && !fp_error_event |=> !fp_error_irq_out)
    else $error("fp error line rose without an error");

  ext_first_stage_a: assert property (@(posedge ref_clk) disable iff (srst)
    ext_reset_in |=> rst_meta_q)
    else $error("external reset missed the first stage");

  ext_second_stage_a: assert property (@(posedge ref_clk) disable iff (srst)
    rst_meta_q |=> rst_sync_q)
    else $error("external reset missed the second stage");

  ext_no_early_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(ext_reset_in) && !core_rst && !core_in_reset |=>
      !core_in_reset)
    else $error("external reset acted before synchronisation");

  factor_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !core_rst |=> $stable(core_factor))
    else $error("core factor changed outside reset");

  test_mode_factor_a: assert property (@(posedge ref_clk) disable iff (srst)
    core_test_mode |-> core_factor == `CSI_FACTOR_TEST)
    else $error("test strap flag without factor four");

endmodule

`default_nettype wire

/* bench/csi_fp_handler.sv */
// partner: fp error handler in the chipset, clears the line by an i/o write
// assumes inputs settled at the falling edge of ref_clk
`timescale 1ns/10ps
`default_nettype none

module csi_fp_handler (
  input wire logic ref_clk,
  input wire logic fp_error_irq_out,
  input wire logic bad_addr,
  input wire logic [3:0] delay,
  output var csi_pkg::csi_io_wr_t io_wr
);
  int n;
  logic go;
  logic [15:0] a;
  initial begin
    io_wr = '0;
    n = 0;
    forever begin
      @(negedge ref_clk);
      // idle address toggles; only the strobe qualifies a write
      a = ~io_wr.addr;
      go = 1'b0;
      n = (fp_error_irq_out === 1'b1) ? n + 1 : 0;
      if (n > delay) begin
        a = bad_addr ? 16'h00F2 : (delay[0] ? 16'h00F1 : 16'h00F0);
        go = 1'b1;
        n = 0;
      end
      io_wr <= '{valid: go, addr: a};
    end
  end
endmodule

`default_nettype wire

/* bench/csi_sys_if_tb.sv */
// self-checking bench of the cpu system interface
// assumes csi_pkg compiled first; inputs change at the falling edge
`timescale 1ns/10ps
`default_nettype none

module csi_sys_if_tb;
  logic ref_clk, srst, ext_reset_in, maskable_irq_in, flags_if_bit, irq_service_done;
  logic sys_mgmt_irq_n, fp_error_event, cache_fill, bad_addr;
  logic cache_line_valid, fp_error_irq_out, irq_take, core_in_reset;
  logic system_management_state, in_irq_service, core_test_mode;
  logic [2:0] core_multiplier_select;
  logic [3:0] cache_fill_idx, cache_lookup_idx, core_factor, delay;
  csi_pkg::csi_io_wr_t io_wr;
  int failures, cmp_count, seed, i, k;
  int fac[8] = '{4, 10, 9, 5, 4, 6, 7, 8};

  csi_sys_if u_csi_sys_if (.ref_clk(ref_clk), .srst(srst), .ext_reset_in(ext_reset_in),
    .core_multiplier_select(core_multiplier_select), .maskable_irq_in(maskable_irq_in),
    .flags_if_bit(flags_if_bit), .irq_service_done(irq_service_done),
    .sys_mgmt_irq_n(sys_mgmt_irq_n), .fp_error_event(fp_error_event), .io_wr(io_wr),
    .cache_fill(cache_fill), .cache_fill_idx(cache_fill_idx),
    .cache_lookup_idx(cache_lookup_idx), .cache_line_valid(cache_line_valid),
    .fp_error_irq_out(fp_error_irq_out), .irq_take(irq_take), .core_in_reset(core_in_reset),
    .system_management_state(system_management_state), .in_irq_service(in_irq_service),
    .core_factor(core_factor), .core_test_mode(core_test_mode));
  csi_fp_handler u_csi_fp_handler (.ref_clk(ref_clk), .fp_error_irq_out(fp_error_irq_out),
    .bad_addr(bad_addr), .delay(delay), .io_wr(io_wr));

  // fixed rate, never stopped
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wait_level(input logic want);
    int j;
    for (j = 0; j < 40 && core_in_reset !== want; j++) cyc(1);
    if (j == 40) begin
      failures++;
      $display("mismatch at %0t: reset level not reached", $time);
      conclude();
    end
  endtask
  task automatic pulse_fp();
    fp_error_event = 1'b1;
    cyc(1);
    fp_error_event = 1'b0;
    chk(fp_error_irq_out, 4'h1);
  endtask

  initial begin
    seed = 93;
    {failures, cmp_count} = '0;
    {srst, ext_reset_in, maskable_irq_in, flags_if_bit, irq_service_done} = 5'h10;
    {sys_mgmt_irq_n, fp_error_event, cache_fill, bad_addr} = 4'h9;
    {core_multiplier_select, cache_fill_idx, cache_lookup_idx, delay} = 15'h1004;
    cyc(20);
    srst = 1'b0;
    wait_level(1'b0);
    // every strap code, cache filled before each reset
    for (i = 0; i < 8; i++) begin
      cache_fill = 1'b1;
      cache_fill_idx = 4'($random(seed));
      cyc(1);
      cache_fill = 1'b0;
      cache_lookup_idx = cache_fill_idx;
      cyc(1);
      chk(cache_line_valid, 4'h1);
      core_multiplier_select = 3'(i);
      srst = 1'b1;
      cyc(1 + i % 3);
      srst = 1'b0;
      wait_level(1'b0);
      core_multiplier_select = 3'($random(seed));
      chk(core_factor, 4'(fac[i]));
      chk(core_test_mode, i == 0);
      for (k = 0; k < 16; k++) begin
        cache_lookup_idx = 4'(k);
        cyc(1);
        chk(cache_line_valid, 4'h0);
      end
      chk(core_factor, 4'(fac[i]));
    end
    // masked request, then taken request
    maskable_irq_in = 1'b1;
    for (k = 0; k < 4; k++) begin
      cyc(1);
      chk({irq_take, in_irq_service}, 4'h0);
    end
    flags_if_bit = 1'b1;
    cyc(1);
    chk({irq_take, in_irq_service}, 4'h3);
    cyc(1);
    chk({irq_take, in_irq_service}, 4'h1);
    irq_service_done = 1'b1;
    maskable_irq_in = 1'b0;
    cyc(1);
    irq_service_done = 1'b0;
    chk(in_irq_service, 4'h0);
    // management request wins over a pending maskable one
    {sys_mgmt_irq_n, maskable_irq_in} = 2'h1;
    cyc(1);
    chk({system_management_state, irq_take}, 4'h2);
    {sys_mgmt_irq_n, maskable_irq_in} = 2'h2;
    cyc(2);
    chk(system_management_state, 4'h0);
    // wrong port refused, then F0h and F1h clear
    for (i = 0; i < 2; i++) begin
      bad_addr = 1'b1;
      delay = {3'($random(seed)), i[0]};
      pulse_fp();
      for (k = 0; k < 24; k++) begin
        cyc(1);
        chk(fp_error_irq_out, 4'h1);
      end
      bad_addr = 1'b0;
      for (k = 0; k < 20 && fp_error_irq_out !== 1'b0; k++) cyc(1);
      chk(fp_error_irq_out, 4'h0);
    end
    // resets drop the line
    bad_addr = 1'b1;
    pulse_fp();
    srst = 1'b1;
    cyc(1);
    chk({fp_error_irq_out, core_in_reset}, 4'h1);
    srst = 1'b0;
    wait_level(1'b0);
    pulse_fp();
    ext_reset_in = 1'b1;
    wait_level(1'b1);
    chk(fp_error_irq_out, 4'h0);
    ext_reset_in = 1'b0;
    wait_level(1'b0);
    chk(core_factor, 4'(fac[core_multiplier_select]));
    conclude();
  end
endmodule

`default_nettype wire
